/* core/irq_request_logic.sv */
// interrupt request logic: pending flags, enables, vectoring and context save buffer
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - taken interrupt loads program counter with shared vector address 8
// - one save buffer, one level; second save overwrites, restore gives latest
// - save/restore skip timeout and powerdown status bits; they stay live
// - pin A trigger sets its pending flag regardless of its enable
// - pin B trigger sets its pending flag regardless of its enable
// - basic timer overflow sets its pending flag regardless of enable
// - timer/counter overflow sets its pending flag regardless of enable
// - vectoring needs both enable bit and pending flag of a source
// - pin A wake trigger with matching edge latches its pending flag
// - pin B wake trigger with matching falling direction latches its flag
// - latched wake request vectors immediately once wake-up completes
// - edge field 01 rising, 10 falling, 11 both, 00 reserved
// - pin B triggers only on falling edge
// - all enable bits and pending flags remain readable for polling
// - interrupts need global enable; entry clears it, return sets it
// - pending flags at 0c8h bits 0,1,4,5
// - enable bits at 0c9h, same positions, reset to zero
module irq_request_logic (
    input  wire logic                       clk_sys_in,
    input  wire logic                       srst_in,
    // register port
    input  wire logic [7:0]                 reg_addr_in,
    input  wire logic [7:0]                 reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic [7:0]                      reg_rdata_out,
    // trigger sources
    input  wire logic                       pin_a_in,
    input  wire logic                       pin_b_in,
    input  wire logic                       basic_timer_ovf_in,
    input  wire logic                       timer_counter_ovf_in,
    // core handshake
    input  wire logic                       sleeping_in,
    input  wire logic                       wake_done_in,
    input  wire logic                       instr_boundary_in,
    input  wire logic                       return_from_interrupt_in,
    output logic                            vector_take_out,
    output logic [irq_pkg::PC_W-1:0]        vector_pc_out,
    // context save buffer
    input  wire logic                       push_in,
    input  wire logic                       pop_in,
    input  wire irq_pkg::ctx_t              ctx_live_in,
    output irq_pkg::ctx_t                   ctx_restore_out,
    output logic                            ctx_restore_valid_out
);
    irq_pkg::reg_req_t req;
    logic [7:0]        pending;
    logic [7:0]        enable;
    logic [7:0]        edge_sel;
    logic              global_en;
    logic              wake_latched;
    irq_pkg::ctx_t     saved;
    logic              a_rise;
    logic              a_fall;
    logic              b_rise;
    logic              b_fall;
    logic              a_trig;
    logic              b_trig;
    logic [7:0]        hw_set;
    logic [7:0]        next_pending;
    logic              want_irq;
    logic              take;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    ////////////////////////////////////////////////////////////////////////////////
    // trigger detection

    // pin inputs pass a synchroniser before the edge detector
    pin_edge_sync u_pin_a (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .pin_in     (pin_a_in),
        .rise_out   (a_rise),
        .fall_out   (a_fall)
    );
    pin_edge_sync u_pin_b (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .pin_in     (pin_b_in),
        .rise_out   (b_rise),
        .fall_out   (b_fall)
    );

    // edge field decode; code 00 is reserved and never triggers
    function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
        unique case (sel)
            irq_pkg::EDGE_RISE: edge_match = r;
            irq_pkg::EDGE_FALL: edge_match = f;
            irq_pkg::EDGE_BOTH: edge_match = r | f;
            default:            edge_match = 1'b0;
        endcase
    endfunction

    // the same detector serves wake-up, so a wake edge of the selected
    // direction lands in the flag exactly as a running trigger would
    assign a_trig = edge_match(edge_sel[irq_pkg::EDGE_LO_BIT +: 2], a_rise, a_fall);
    assign b_trig = b_fall;

    // set vector independent of the enable register
    always_comb begin
        hw_set = 8'h00;
        hw_set[irq_pkg::PIN_A_BIT]  = a_trig;
        hw_set[irq_pkg::PIN_B_BIT]  = b_trig;
        hw_set[irq_pkg::BTIMER_BIT] = basic_timer_ovf_in;
        hw_set[irq_pkg::TCOUNT_BIT] = timer_counter_ovf_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pending and enable registers

    // software write first, hardware set OR'd over it so an event is never lost
    always_comb begin
        next_pending = pending;
        if (req.wr && req.addr == irq_pkg::PENDING_ADDR) begin
            next_pending = req.wdata & irq_pkg::SOURCE_MASK;
        end
        next_pending = next_pending | hw_set;
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pending <= 8'h00;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            enable <= 8'h00;
        end else if (req.wr && req.addr == irq_pkg::ENABLE_ADDR) begin
            enable <= req.wdata & irq_pkg::SOURCE_MASK;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            edge_sel <= irq_pkg::EDGE_SEL_RESET;
        end else if (req.wr && req.addr == irq_pkg::EDGE_SEL_ADDR) begin
            edge_sel <= req.wdata & irq_pkg::EDGE_SEL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // vectoring

    assign want_irq = |(pending & enable);
    // while asleep nothing is taken; the request waits for wake-up completion
    assign take = global_en && want_irq && !sleeping_in
                  && (instr_boundary_in || wake_latched);

    // remembers that a request sat pending across a sleep period
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wake_latched <= 1'b0;
        end else if (take) begin
            wake_latched <= 1'b0;
        end else if (wake_done_in && want_irq) begin
            wake_latched <= 1'b1;
        end
    end

    // global enable: software write, cleared on entry, set by return
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            global_en <= 1'b0;
        end else if (take) begin
            global_en <= 1'b0;
        end else if (return_from_interrupt_in) begin
            global_en <= 1'b1;
        end else if (req.wr && req.addr == irq_pkg::GLOBAL_ADDR) begin
            global_en <= req.wdata[irq_pkg::GIE_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            vector_take_out <= 1'b0;
            vector_pc_out   <= '0;
        end else begin
            vector_take_out <= take;
            vector_pc_out   <= take ? irq_pkg::VECTOR_ADDR : vector_pc_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // context save buffer

    // single level: a later save simply overwrites the earlier one
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            saved <= '0;
        end else if (push_in) begin
            saved <= ctx_live_in;
        end
    end

    // status bits come from the live flag register, not the buffer
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            ctx_restore_out       <= '0;
            ctx_restore_valid_out <= 1'b0;
        end else begin
            ctx_restore_valid_out <= pop_in;
            if (pop_in) begin
                ctx_restore_out.acc   <= saved.acc;
                ctx_restore_out.flags <= (saved.flags & ~irq_pkg::FLAG_LIVE_MASK)
                                         | (ctx_live_in.flags & irq_pkg::FLAG_LIVE_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read port: data valid in the cycle after the strobe

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                irq_pkg::PENDING_ADDR:  reg_rdata_out <= pending;
                irq_pkg::ENABLE_ADDR:   reg_rdata_out <= enable;
                irq_pkg::EDGE_SEL_ADDR: reg_rdata_out <= edge_sel;
                irq_pkg::GLOBAL_ADDR:   reg_rdata_out <= {global_en, 7'h00};
                default:                reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    a_vector_addr: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        vector_take_out |-> vector_pc_out == irq_pkg::VECTOR_ADDR)
        else $error("vector address wrong");

    a_pc_holds: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !take |=> $stable(vector_pc_out))
        else $error("vector address moved without a take");

    a_restore_latest: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        push_in ##1 (!push_in && pop_in) |=> ctx_restore_out.acc == $past(ctx_live_in.acc, 2))
        else $error("restore not latest save");

    a_push_store: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        push_in |=> saved == $past(ctx_live_in))
        else $error("save buffer missed a push");

    a_valid_pulse: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        ctx_restore_valid_out == $past(pop_in))
        else $error("restore valid not one cycle after pop");

    a_live_status: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        pop_in |=> (ctx_restore_out.flags & irq_pkg::FLAG_LIVE_MASK)
                   == ($past(ctx_live_in.flags) & irq_pkg::FLAG_LIVE_MASK))
        else $error("status bits restored from buffer");

    a_pin_a_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        a_trig |=> pending[irq_pkg::PIN_A_BIT])
        else $error("pin a flag not set");

    a_timer_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        basic_timer_ovf_in |=> pending[irq_pkg::BTIMER_BIT])
        else $error("basic timer flag not set");

    a_tcount_set: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        timer_counter_ovf_in |=> pending[irq_pkg::TCOUNT_BIT])
        else $error("timer counter flag not set");

    a_pin_b_fall: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        $fell(pin_b_in) ##1 !pin_b_in ##1 !pin_b_in |=> pending[irq_pkg::PIN_B_BIT])
        else $error("pin b fall missed");

    a_b_rise_ignored: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        b_rise && !pending[irq_pkg::PIN_B_BIT] && !req.wr
        |=> !pending[irq_pkg::PIN_B_BIT])
        else $error("pin b rising edge set its flag");

    a_reserved_code: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        edge_sel[irq_pkg::EDGE_LO_BIT +: 2] == 2'h0 && !pending[irq_pkg::PIN_A_BIT] && !req.wr
        |=> !pending[irq_pkg::PIN_A_BIT])
        else $error("reserved edge code triggered pin a");

    a_rise_only: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        edge_sel[irq_pkg::EDGE_LO_BIT +: 2] == irq_pkg::EDGE_RISE && !a_rise
        && !pending[irq_pkg::PIN_A_BIT] && !req.wr |=> !pending[irq_pkg::PIN_A_BIT])
        else $error("rising code triggered without a rising edge");

    a_edge_bits: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (edge_sel & ~irq_pkg::EDGE_SEL_MASK) == 8'h00)
        else $error("edge select holds bits outside its field");

    a_source_bits: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        ((pending | enable) & ~irq_pkg::SOURCE_MASK) == 8'h00)
        else $error("flag or enable outside source positions");

    a_need_enable: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        vector_take_out |-> $past(|(pending & enable)) && $past(global_en)
                            && !$past(sleeping_in))
        else $error("vector without enabled source");

    a_sleep_block: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        sleeping_in |=> !vector_take_out)
        else $error("vector taken while asleep");

    a_wake_vector: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        wake_latched && global_en && want_irq && !sleeping_in |=> vector_take_out)
        else $error("latched wake request not taken");

    a_gie_cleared: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        take |=> !global_en && vector_take_out)
        else $error("global enable not cleared");

    a_return_from_interrupt_sets: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        return_from_interrupt_in && !take |=> global_en)
        else $error("return did not set global enable");

    a_no_auto_clear: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        (pending[irq_pkg::PIN_A_BIT] && !(req.wr && req.addr == irq_pkg::PENDING_ADDR))
        |=> pending[irq_pkg::PIN_A_BIT])
        else $error("pending flag cleared by hardware");

    a_read_idle: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        !req.rd |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");

    a_read_pending: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        req.rd && req.addr == irq_pkg::PENDING_ADDR |=> reg_rdata_out == $past(pending))
        else $error("pending register read wrong");

    a_read_enable: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        req.rd && req.addr == irq_pkg::ENABLE_ADDR |=> reg_rdata_out == $past(enable))
        else $error("enable register read wrong");

    a_sync_delay: assert property (@(posedge clk_sys_in) disable iff (srst_in)
        $fell(pin_a_in) ##1 !pin_a_in |=> a_fall)
        else $error("pin a fall not seen after two flops");
endmodule
`default_nettype wire

/* core/irq_pkg.sv */
// constants, register map and carrier types of the interrupt request logic
package irq_pkg;
    // register offsets of the special function space
    localparam logic [7:0] EDGE_SEL_ADDR = 8'hbf;
    localparam logic [7:0] PENDING_ADDR  = 8'hc8;
    localparam logic [7:0] ENABLE_ADDR   = 8'hc9;
    localparam logic [7:0] GLOBAL_ADDR   = 8'hdf;
    // bit positions shared by pending and enable registers
    localparam int PIN_A_BIT   = 0;
    localparam int PIN_B_BIT   = 1;
    localparam int BTIMER_BIT  = 4;
    localparam int TCOUNT_BIT  = 5;
    localparam logic [7:0] SOURCE_MASK = 8'h33;
    // edge select field at bits 4:3
    localparam int EDGE_LO_BIT = 3;
    localparam logic [7:0] EDGE_SEL_MASK  = 8'h18;
    localparam logic [7:0] EDGE_SEL_RESET = 8'h10;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // global enable sits at bit 7 of the stack pointer register
    localparam int GIE_BIT = 7;
    // flag register status bits kept live over a restore
    localparam logic [7:0] FLAG_LIVE_MASK = 8'hc0;
    // program counter
    localparam int PC_W = 12;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h008;

    // state saved by the one-level buffer
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
    } ctx_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage

/* core/pin_edge_sync.sv */
// synchroniser and edge detector for one external trigger pin
`timescale 1ns/10ps
`default_nettype none
module pin_edge_sync (
    input  wire logic clk_sys_in,
    input  wire logic srst_in,
    input  wire logic pin_in,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta;
    logic stable;
    logic last;

    // two-flop synchroniser then edge register; the first flop feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta   <= 1'b1;
            stable <= 1'b1;
            last   <= 1'b1;
        end else begin
            meta   <= pin_in;
            stable <= meta;
            last   <= stable;
        end
    end

    // one-cycle pulses, so each edge is seen exactly once
    assign rise_out = stable & ~last;
    assign fall_out = ~stable & last;
endmodule
`default_nettype wire

/* testbench/trigger_source_model.sv */
// far-side model: trigger pins and timer overflow pulses feeding the block
`timescale 1ns/10ps
`default_nettype none
module trigger_source_model (
    input  wire logic clk_sys_in,
    output logic      pin_a_out,
    output logic      pin_b_out,
    output logic      basic_timer_ovf_out,
    output logic      timer_counter_ovf_out
);
    // pins idle high so release of reset sees no false falling edge
    initial begin
        pin_a_out = 1'b1;
        pin_b_out = 1'b1;
        basic_timer_ovf_out = 1'b0;
        timer_counter_ovf_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // pin levels change right after an edge; the block synchronises them
    task automatic set_pin(input logic pin_b, input logic level);
        @(posedge clk_sys_in);
        if (pin_b) begin
            pin_b_out <= level;
        end else begin
            pin_a_out <= level;
        end
    endtask
    // one overflow is one cycle high, never stretched
    task automatic pulse(input logic tcount);
        @(posedge clk_sys_in);
        if (tcount) begin
            timer_counter_ovf_out <= 1'b1;
        end else begin
            basic_timer_ovf_out <= 1'b1;
        end
        @(posedge clk_sys_in);
        timer_counter_ovf_out <= 1'b0;
        basic_timer_ovf_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the interrupt request logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic          clk_sys_in;
    logic          srst_in;
    logic [7:0]    addr, wdata, rdata;
    logic          wr, rd, boundary, sleeping, wake_done, return_from_interrupt, push, pop, vtake, rvalid;
    logic          pin_a, pin_b, bt_ovf, tc_ovf;
    logic [11:0]   vpc;
    irq_pkg::ctx_t live, restored;
    int            n_fail, comparisons;

    trigger_source_model u_src (.clk_sys_in(clk_sys_in), .pin_a_out(pin_a), .pin_b_out(pin_b),
        .basic_timer_ovf_out(bt_ovf), .timer_counter_ovf_out(tc_ovf));
    irq_request_logic u_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pin_a_in(pin_a), .pin_b_in(pin_b), .basic_timer_ovf_in(bt_ovf),
        .timer_counter_ovf_in(tc_ovf), .sleeping_in(sleeping), .wake_done_in(wake_done),
        .instr_boundary_in(boundary), .return_from_interrupt_in(return_from_interrupt), .vector_take_out(vtake),
        .vector_pc_out(vpc), .push_in(push), .pop_in(pop), .ctx_live_in(live),
        .ctx_restore_out(restored), .ctx_restore_valid_out(rvalid));

    // 40 ns period
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d, failed %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 check("rdata", {8'h00, rdata}, {8'h00, exp});
    endtask
    // bounded watch for the one-cycle jump pulse
    task automatic wait_vec(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk_sys_in);
            #1 if (vtake === 1'b1) seen = 1'b1;
        end
        check("vector_take", {15'h0, seen}, {15'h0, exp});
    endtask
    task automatic pulse_core(input logic is_return_from_interrupt);
        @(posedge clk_sys_in);
        if (is_return_from_interrupt) begin
            return_from_interrupt <= 1'b1;
        end else begin
            wake_done <= 1'b1;
        end
        @(posedge clk_sys_in);
        return_from_interrupt <= 1'b0;
        wake_done <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [1:0] code;
        n_fail = 0;
        comparisons = 0;
        srst_in = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        boundary = 1'b0;
        sleeping = 1'b0;
        wake_done = 1'b0;
        return_from_interrupt = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        live = 16'h0000;
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        // reset values and an unmapped address
        reg_read(irq_pkg::EDGE_SEL_ADDR, 8'h10);
        reg_read(irq_pkg::PENDING_ADDR, 8'h00);
        reg_read(irq_pkg::ENABLE_ADDR, 8'h00);
        reg_read(irq_pkg::GLOBAL_ADDR, 8'h00);
        reg_read(8'h00, 8'h00);
        // overflows set flags with enables off and no jump follows
        u_src.pulse(1'b0);
        reg_read(irq_pkg::PENDING_ADDR, 8'h10);
        u_src.pulse(1'b1);
        reg_read(irq_pkg::PENDING_ADDR, 8'h30);
        reg_write(irq_pkg::PENDING_ADDR, 8'h00);
        reg_read(irq_pkg::PENDING_ADDR, 8'h00);
        // pin b: only the falling edge counts, once per edge
        u_src.set_pin(1'b1, 1'b0);
        repeat (5) @(posedge clk_sys_in);
        reg_read(irq_pkg::PENDING_ADDR, 8'h02);
        reg_write(irq_pkg::PENDING_ADDR, 8'h00);
        u_src.set_pin(1'b1, 1'b1);
        repeat (5) @(posedge clk_sys_in);
        reg_read(irq_pkg::PENDING_ADDR, 8'h00);
        // pin a under every edge code, reserved code included
        for (int i = 0; i < 4; i++) begin
            code = 2'(i + 1);
            reg_write(irq_pkg::EDGE_SEL_ADDR, {3'h0, code, 3'h0});
            reg_read(irq_pkg::EDGE_SEL_ADDR, {3'h0, code, 3'h0});
            reg_write(irq_pkg::PENDING_ADDR, 8'h00);
            u_src.set_pin(1'b0, 1'b0);
            repeat (5) @(posedge clk_sys_in);
            reg_read(irq_pkg::PENDING_ADDR, {7'h0, code[1]});
            reg_write(irq_pkg::PENDING_ADDR, 8'h00);
            u_src.set_pin(1'b0, 1'b1);
            repeat (5) @(posedge clk_sys_in);
            reg_read(irq_pkg::PENDING_ADDR, {7'h0, code[0]});
        end
        // set beats a software clear in the same cycle
        u_src.pulse(1'b1);
        fork
            reg_write(irq_pkg::PENDING_ADDR, 8'h00);
            u_src.pulse(1'b0);
        join
        reg_read(irq_pkg::PENDING_ADDR, 8'h10);
        // vectoring needs enable, pending and global enable
        reg_write(irq_pkg::PENDING_ADDR, 8'h00);
        reg_write(irq_pkg::ENABLE_ADDR, 8'hff);
        reg_read(irq_pkg::ENABLE_ADDR, 8'h33);
        reg_write(irq_pkg::ENABLE_ADDR, 8'h10);
        boundary <= 1'b1;
        reg_write(irq_pkg::GLOBAL_ADDR, 8'h80);
        u_src.pulse(1'b1);
        wait_vec(1'b0);
        u_src.pulse(1'b0);
        wait_vec(1'b1);
        check("vector_pc", {4'h0, vpc}, {4'h0, irq_pkg::VECTOR_ADDR});
        reg_read(irq_pkg::GLOBAL_ADDR, 8'h00);
        reg_read(irq_pkg::PENDING_ADDR, 8'h30);
        reg_write(irq_pkg::PENDING_ADDR, 8'h00);
        pulse_core(1'b1);
        reg_read(irq_pkg::GLOBAL_ADDR, 8'h80);
        // wake by pin b: latched while asleep, taken once awake
        reg_write(irq_pkg::ENABLE_ADDR, 8'h02);
        sleeping <= 1'b1;
        boundary <= 1'b0;
        u_src.set_pin(1'b1, 1'b0);
        wait_vec(1'b0);
        reg_read(irq_pkg::PENDING_ADDR, 8'h02);
        @(posedge clk_sys_in);
        sleeping <= 1'b0;
        pulse_core(1'b0);
        wait_vec(1'b1);
        // two saves then a restore with live status bits changed
        @(posedge clk_sys_in);
        live <= 16'h113c;
        push <= 1'b1;
        @(posedge clk_sys_in);
        live <= 16'ha51a;
        @(posedge clk_sys_in);
        push <= 1'b0;
        pop <= 1'b1;
        live <= 16'h00c0;
        @(posedge clk_sys_in);
        pop <= 1'b0;
        #1 check("restore", restored, 16'ha5da);
        check("restore_valid", {15'h0, rvalid}, 16'h0001);
        @(posedge clk_sys_in);
        #1 check("restore_valid", {15'h0, rvalid}, 16'h0000);
        // wake by pin a on its selected falling edge
        reg_write(irq_pkg::PENDING_ADDR, 8'h00);
        reg_write(irq_pkg::ENABLE_ADDR, 8'h01);
        reg_write(irq_pkg::EDGE_SEL_ADDR, 8'h10);
        reg_write(irq_pkg::GLOBAL_ADDR, 8'h80);
        sleeping <= 1'b1;
        u_src.set_pin(1'b0, 1'b0);
        wait_vec(1'b0);
        reg_read(irq_pkg::PENDING_ADDR, 8'h01);
        @(posedge clk_sys_in);
        sleeping <= 1'b0;
        pulse_core(1'b0);
        wait_vec(1'b1);
        // reset again in mid-run; pins parked high first so no false edge follows
        u_src.set_pin(1'b0, 1'b1);
        u_src.set_pin(1'b1, 1'b1);
        srst_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        #1 check("restore", restored, 16'h0000);
        check("vector_take", {15'h0, vtake}, 16'h0000);
        reg_read(irq_pkg::PENDING_ADDR, 8'h00);
        reg_read(irq_pkg::ENABLE_ADDR, 8'h00);
        reg_read(irq_pkg::EDGE_SEL_ADDR, 8'h10);
        reg_read(irq_pkg::GLOBAL_ADDR, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
